// ==== src/wdit_defines.svh ====
// register addresses, field positions, reset values and timing counts of the watch unit
// assumes a 40 MHz system clock where one state is one clock period
`ifndef WDIT_DEFINES_SVH
`define WDIT_DEFINES_SVH

// lower 16 address bits
`define WDIT_ADDR_CSR 16'hFFA8
`define WDIT_ADDR_CNT 16'hFFA9
`define WDIT_ADDR_RSTC_WR 16'hFFAA
`define WDIT_ADDR_RSTC_RD 16'hFFAB

// field positions
`define WDIT_CSR_OVF 7
`define WDIT_CSR_MODE 6
`define WDIT_CSR_TME 5
`define WDIT_CSR_CKS_HI 2
`define WDIT_RSTC_WATCHDOG_RESET_FLAG 7
`define WDIT_RSTC_OE 6

// reset values and reserved read-as-one masks
`define WDIT_CSR_RESET 8'h18
`define WDIT_CNT_RESET 8'h00
`define WDIT_RSTC_RESET 8'h3F
`define WDIT_CSR_RSVD 8'h18
`define WDIT_RSTC_RSVD 8'h3F

// timing: states are clock periods of the system clock
`define WDIT_CLK_MHZ 40
`define WDIT_STATE_NS 25
`define WDIT_INT_RST_STATES 518
`define WDIT_EXT_RST_STATES 132
`define WDIT_INT_RST_CYC ((`WDIT_INT_RST_STATES * `WDIT_STATE_NS * `WDIT_CLK_MHZ + 999) / 1000)
`define WDIT_EXT_RST_CYC ((`WDIT_EXT_RST_STATES * `WDIT_STATE_NS * `WDIT_CLK_MHZ + 999) / 1000)

`endif

// ==== src/wdit_pkg.sv ====
// types shared by the watch unit modules
// assumes nothing beyond a SystemVerilog compiler
package wdit_pkg;

   // write keys carried in the upper byte of a word write
   typedef enum logic [7:0] {
      WDIT_KEY_CNT = 8'h5A,
      WDIT_KEY_CSR = 8'hA5
   } wdit_key_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic ovf;
      logic mode;
      logic count_enable;
      logic [2:0] cks;
      logic ovf_seen;
      logic watchdog_reset_flag;
      logic reset_output_enable;
      logic watchdog_reset_flag_seen;
      logic [7:0] rdata;
   } wdit_core_t;

   typedef struct packed {
      logic [11:0] div;
   } wdit_pre_t;

   typedef struct packed {
      logic [9:0] int_cnt;
      logic [7:0] ext_cnt;
   } wdit_pulse_t;

endpackage

// ==== src/wdit_if.sv ====
// internal link between the watch unit core, its prescaler and its reset pulse timer
// assumes all parties run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface wdit_if;
   logic [2:0] cks;
   logic tick;
   logic fire;
   logic fire_ext;
   logic rst_int;
   logic rst_ext;

   modport core (output cks, output fire, output fire_ext,
                 input tick, input rst_int, input rst_ext);
   modport pre (input cks, output tick);
   modport pulse (input fire, input fire_ext, output rst_int, output rst_ext);
endinterface
`default_nettype wire

// ==== src/wdit_prescaler.sv ====
// free-running system clock prescaler with an eight-way divide select
// assumes clock, synchronous reset and clock enable shared with the core
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.svh"
module wdit_prescaler
   import wdit_pkg::*;
(
   // system
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   // core link
   wdit_if.pre lnk
);

   wdit_pre_t st_r;
   wdit_pre_t st_nxt;
   logic [11:0] msk;

   // divide by 2,32,64,128,256,512,2048,4096
   always_comb
   begin
      unique case (lnk.cks)
         3'h0: msk = 12'h001;
         3'h1: msk = 12'h01F;
         3'h2: msk = 12'h03F;
         3'h3: msk = 12'h07F;
         3'h4: msk = 12'h0FF;
         3'h5: msk = 12'h1FF;
         3'h6: msk = 12'h7FF;
         3'h7: msk = 12'hFFF;
      endcase
   end

   // one tick per selected period
   assign lnk.tick = clk_en && ((st_r.div & msk) == msk);

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.div = st_r.div + 12'h001;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         st_r <= '0;
      else if (clk_en)
         st_r <= st_nxt;
   end

   chk_tick_div2 : assert property (@(posedge clock) disable iff (srst)
      (lnk.cks == 3'h0 && clk_en && lnk.tick) |=> (clk_en && lnk.cks == 3'h0) |-> !lnk.tick)
      else $error("divide by 2 ticked on two adjacent cycles");

endmodule // wdit_prescaler
`default_nettype wire

// ==== src/wdit_reset_pulse.sv ====
// stretches a watchdog overflow into the internal and external reset pulses
// assumes fire is a one-cycle pulse qualified by the clock enable
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.svh"
module wdit_reset_pulse
   import wdit_pkg::*;
(
   // system
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   // core link
   wdit_if.pulse lnk
);

   localparam logic [9:0] INT_CYC = 10'(`WDIT_INT_RST_CYC);
   localparam logic [7:0] EXT_CYC = 8'(`WDIT_EXT_RST_CYC);

   wdit_pulse_t st_r;
   wdit_pulse_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (st_r.int_cnt != 10'h000)
         st_nxt.int_cnt = st_r.int_cnt - 10'h001;
      if (st_r.ext_cnt != 8'h00)
         st_nxt.ext_cnt = st_r.ext_cnt - 8'h01;
      if (lnk.fire)
      begin
         st_nxt.int_cnt = INT_CYC;
         st_nxt.ext_cnt = lnk.fire_ext ? EXT_CYC : 8'h00;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         st_r <= '0;
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign lnk.rst_int = (st_r.int_cnt != 10'h000);
   assign lnk.rst_ext = (st_r.ext_cnt != 8'h00);

   chk_int_load : assert property (@(posedge clock) disable iff (srst)
      (lnk.fire && clk_en) |=> (st_r.int_cnt == 10'd518))
      else $error("internal reset not loaded with 518 states");

   chk_int_count : assert property (@(posedge clock) disable iff (srst)
      (lnk.rst_int && clk_en && !lnk.fire) |=> (st_r.int_cnt == $past(st_r.int_cnt) - 10'h001))
      else $error("internal reset pulse did not count down");

   chk_ext_len : assert property (@(posedge clock) disable iff (srst)
      (lnk.fire && clk_en) |=> (st_r.ext_cnt == ($past(lnk.fire_ext) ? 8'd132 : 8'h00)))
      else $error("external reset pulse length wrong");

endmodule // wdit_reset_pulse
`default_nettype wire

// ==== src/wdit_top.sv ====
// watch unit: 8-bit watchdog and interval timer with keyed word writes and byte reads
// assumes a cpu bus on the system clock, srst driven from the external reset pin
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.svh"
module wdit_top
   import wdit_pkg::*;
(
   // system
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic standby,
   // cpu bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // reset and interrupt
   output logic chip_reset,
   output logic irq,
   output logic reset_output_pin_o,
   output logic reset_output_pin_oe
);

   localparam logic [7:0] CSR_RST = `WDIT_CSR_RESET;
   localparam logic [7:0] RSTC_RST = `WDIT_RSTC_RESET;
   localparam wdit_core_t CORE_RST = '{
      cnt: `WDIT_CNT_RESET,
      ovf: CSR_RST[`WDIT_CSR_OVF],
      mode: CSR_RST[`WDIT_CSR_MODE],
      count_enable: CSR_RST[`WDIT_CSR_TME],
      cks: CSR_RST[`WDIT_CSR_CKS_HI:0],
      ovf_seen: 1'b0,
      watchdog_reset_flag: RSTC_RST[`WDIT_RSTC_WATCHDOG_RESET_FLAG],
      reset_output_enable: RSTC_RST[`WDIT_RSTC_OE],
      watchdog_reset_flag_seen: 1'b0,
      rdata: 8'h00
   };

   wdit_if lnk ();

   wdit_core_t st_r;
   wdit_core_t st_nxt;

   logic csr_wr;
   logic rstc_wr;
   logic key_cnt;
   logic key_csr;
   logic cnt_write;
   logic ctl_write;
   logic ovf_clr;
   logic watchdog_reset_flag_clr;
   logic step;
   logic wrap;
   logic [7:0] csr_view;
   logic [7:0] rstc_view;

   wdit_prescaler u_pre (
      .clock (clock),
      .srst (srst),
      .clk_en (clk_en),
      .lnk (lnk.pre)
   );

   wdit_reset_pulse u_pulse (
      .clock (clock),
      .srst (srst),
      .clk_en (clk_en),
      .lnk (lnk.pulse)
   );

   // write decode: word writes only, keyed by the upper byte
   assign csr_wr = bus_wr && bus_word && (bus_addr == `WDIT_ADDR_CSR);
   assign rstc_wr = bus_wr && bus_word && (bus_addr == `WDIT_ADDR_RSTC_WR);
   assign key_cnt = (bus_wdata[15:8] == WDIT_KEY_CNT);
   assign key_csr = (bus_wdata[15:8] == WDIT_KEY_CSR);
   assign cnt_write = csr_wr && key_cnt;
   assign ctl_write = csr_wr && key_csr;
   assign ovf_clr = ctl_write && !bus_wdata[`WDIT_CSR_OVF] && st_r.ovf_seen;
   assign watchdog_reset_flag_clr = rstc_wr && key_csr && (bus_wdata[7:0] == 8'h00)
                     && st_r.watchdog_reset_flag_seen;

   // a counter write wins over a coincident tick
   assign step = st_r.count_enable && lnk.tick && !cnt_write && !lnk.rst_int;
   assign wrap = step && (&st_r.cnt);

   assign lnk.cks = st_r.cks;
   assign lnk.fire = wrap && st_r.mode;
   assign lnk.fire_ext = st_r.reset_output_enable;

   // read views, reserved bits forced to one
   assign csr_view = {st_r.ovf, st_r.mode, st_r.count_enable, 2'b00, st_r.cks} | `WDIT_CSR_RSVD;
   assign rstc_view = {st_r.watchdog_reset_flag, st_r.reset_output_enable, 6'h00} | `WDIT_RSTC_RSVD;

   always_comb
   begin
      st_nxt = st_r;

      // counter
      if (step)
         st_nxt.cnt = st_r.cnt + 8'h01;
      if (cnt_write)
         st_nxt.cnt = bus_wdata[7:0];

      // status and control
      if (ctl_write)
      begin
         st_nxt.mode = bus_wdata[`WDIT_CSR_MODE];
         st_nxt.count_enable = bus_wdata[`WDIT_CSR_TME];
         st_nxt.cks = bus_wdata[`WDIT_CSR_CKS_HI:0];
      end
      if (ovf_clr)
         st_nxt.ovf = 1'b0;
      if (wrap)
         st_nxt.ovf = 1'b1;

      // reset control
      if (rstc_wr && key_cnt)
         st_nxt.reset_output_enable = bus_wdata[`WDIT_RSTC_OE];
      if (watchdog_reset_flag_clr)
         st_nxt.watchdog_reset_flag = 1'b0;
      if (lnk.fire)
         st_nxt.watchdog_reset_flag = 1'b1;

      // byte reads; remember a flag seen as one
      if (bus_rd)
      begin
         unique case (bus_addr)
            `WDIT_ADDR_CSR: st_nxt.rdata = csr_view;
            `WDIT_ADDR_CNT: st_nxt.rdata = st_r.cnt;
            `WDIT_ADDR_RSTC_RD: st_nxt.rdata = rstc_view;
            default: st_nxt.rdata = 8'h00;
         endcase
         if (bus_addr == `WDIT_ADDR_CSR && st_r.ovf)
            st_nxt.ovf_seen = 1'b1;
         if (bus_addr == `WDIT_ADDR_RSTC_RD && st_r.watchdog_reset_flag)
            st_nxt.watchdog_reset_flag_seen = 1'b1;
      end

      // standby keeps the clock select
      if (standby)
      begin
         st_nxt.ovf = 1'b0;
         st_nxt.mode = 1'b0;
         st_nxt.count_enable = 1'b0;
      end

      // chip held in watchdog reset: reset control survives
      if (lnk.rst_int)
      begin
         st_nxt.ovf = CORE_RST.ovf;
         st_nxt.mode = CORE_RST.mode;
         st_nxt.count_enable = CORE_RST.count_enable;
         st_nxt.cks = CORE_RST.cks;
         st_nxt.watchdog_reset_flag = st_r.watchdog_reset_flag;
         st_nxt.reset_output_enable = st_r.reset_output_enable;
      end

      // halted counter sits at zero
      if (!st_nxt.count_enable)
         st_nxt.cnt = CORE_RST.cnt;
      if (!st_nxt.ovf)
         st_nxt.ovf_seen = 1'b0;
      if (!st_nxt.watchdog_reset_flag)
         st_nxt.watchdog_reset_flag_seen = 1'b0;
   end

   // srst stands for the external reset pin, the only reset clearing reset control
   always_ff @(posedge clock)
   begin
      if (srst)
         st_r <= CORE_RST;
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign bus_rdata = st_r.rdata;
   assign chip_reset = lnk.rst_int;
   assign irq = st_r.ovf && !st_r.mode;
   // open drain: only ever pulls low
   assign reset_output_pin_o = 1'b0;
   assign reset_output_pin_oe = lnk.rst_ext;

   default clocking dc @(posedge clock);
   endclocking
   default disable iff (srst);

   chk_cnt_step : assert property (
      (clk_en && step && !standby && !(ctl_write && !bus_wdata[`WDIT_CSR_TME]))
      |=> (st_r.cnt == $past(st_r.cnt) + 8'h01))
      else $error("counter did not step on a tick");

   chk_ovf_set : assert property (
      (clk_en && wrap && !lnk.rst_int) |=> st_r.ovf)
      else $error("overflow flag not set on wrap");

   chk_cnt_halt : assert property (
      !st_r.count_enable |-> (st_r.cnt == 8'h00))
      else $error("halted counter not at zero");

   chk_standby_keep : assert property (
      (clk_en && standby && !lnk.rst_int)
      |=> (!st_r.ovf && !st_r.mode && !st_r.count_enable && st_r.cks == $past(st_r.cks)))
      else $error("standby did not clear control bits or lost clock select");

   chk_ovf_clear : assert property (
      $fell(st_r.ovf) |-> ($past(ovf_clr) || $past(standby) || $past(lnk.rst_int)))
      else $error("overflow flag cleared without a legal clear");

   chk_rsvd_read : assert property (
      (clk_en && bus_rd && bus_addr == `WDIT_ADDR_RSTC_RD) |=> (bus_rdata[5:0] == 6'h3F))
      else $error("reserved reset control bits not read as one");

   chk_rstc_keep : assert property (
      (clk_en && lnk.rst_int) |=> (st_r.reset_output_enable == $past(st_r.reset_output_enable)))
      else $error("watchdog reset disturbed the output enable");

   chk_wdt_fire : assert property (
      (clk_en && lnk.fire) |=> (st_r.watchdog_reset_flag && chip_reset && reset_output_pin_oe == $past(st_r.reset_output_enable)))
      else $error("watchdog overflow did not raise reset and flag");

   chk_irq_mode : assert property (
      (clk_en && wrap && !st_r.mode) |=> (irq && !chip_reset))
      else $error("interval overflow gave no interrupt");

   cov_wdt_reset : cover property (lnk.fire && st_r.reset_output_enable);
   cov_interval : cover property (clk_en && wrap && !st_r.mode);
   cov_watchdog_reset_flag_clear : cover property (clk_en && watchdog_reset_flag_clr);

endmodule // wdit_top
`default_nettype wire

// ==== tb/wdit_far_end.sv ====
// far side of the watch unit: chip reset logic and the pulled-up open-drain reset line
// assumes the watch unit runs on the same clock and drives the pin as output plus enable
`timescale 1ns/1ps
`default_nettype none
module wdit_far_end
(
   // system
   input wire logic clock,
   // reset lines from the watch unit
   input wire logic chip_reset,
   input wire logic pin_o,
   input wire logic pin_oe,
   // observations
   output logic pin_level,
   output int int_len,
   output int ext_len
);
   logic prev_r = 1'b0;

   // pull-up holds the line high unless the unit drives it
   assign pin_level = pin_oe ? pin_o : 1'b1;

   // measure the internal and external pulse widths of the latest watchdog reset
   initial int_len = 0;
   initial ext_len = 0;
   // plain always: the lengths also carry start values from initial blocks
   always @(posedge clock)
   begin
      prev_r <= chip_reset;
      if (chip_reset && !prev_r)
      begin
         int_len <= 1;
         ext_len <= pin_level ? 0 : 1;
      end
      else
      begin
         if (chip_reset)
            int_len <= int_len + 1;
         if (!pin_level)
            ext_len <= ext_len + 1;
      end
   end
endmodule // wdit_far_end
`default_nettype wire

// ==== tb/watchdog_interval_timer_bench.sv ====
// self-checking bench for the watch unit: keyed word writes, byte reads, pulse widths
// assumes the design and package under src/ and the far end model under tb/
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.svh"
module watchdog_interval_timer_bench
   import wdit_pkg::*;
;
   logic clock, srst, clk_en, standby, bus_rd, bus_wr, bus_word;
   logic [15:0] bus_addr, bus_wdata;
   logic [7:0] bus_rdata;
   logic chip_reset, irq, pin_o, pin_oe, pin_level;
   int int_len, ext_len;
   int errors = 0;
   int compares = 0;
   int div_tab[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wdit_top i_dut (.clock(clock), .srst(srst), .clk_en(clk_en), .standby(standby),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_word(bus_word),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .chip_reset(chip_reset), .irq(irq),
      .reset_output_pin_o(pin_o), .reset_output_pin_oe(pin_oe));

   wdit_far_end i_far (.clock(clock), .chip_reset(chip_reset), .pin_o(pin_o),
      .pin_oe(pin_oe), .pin_level(pin_level), .int_len(int_len), .ext_len(ext_len));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic wrap_up();
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t byte got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      compares++;
      if (got != exp)
      begin
         errors++;
         $display("BAD %0t length got %0d expected %0d", $time, got, exp);
      end
   endtask

   // keyed write, word form unless told otherwise
   task automatic wr(input logic [15:0] a, input logic [7:0] key, input logic [7:0] d,
                     input logic word = 1'b1);
      @(posedge clock);
      bus_wr <= 1'b1;
      bus_word <= word;
      bus_addr <= a;
      bus_wdata <= {key, d};
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask

   // byte read, data lands on the same edge that takes the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata, exp);
   endtask

   // wait for irq (sel 0) or chip_reset (sel 1) to reach a level
   task automatic wait_for(input int sel, input logic lvl, input int limit);
      for (int i = 0; i < limit; i++)
      begin
         @(posedge clock);
         #1;
         if ((sel == 0 ? irq : chip_reset) === lvl)
            return;
      end
      errors++;
      $display("BAD %0t wait ran out", $time);
   endtask

   initial
   begin
      #(25 * 60000);
      errors++;
      wrap_up();
   end

   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      standby = 1'b0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_word = 1'b0;
      bus_addr = 16'h0000;
      bus_wdata = 16'h0000;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      rd(`WDIT_ADDR_CSR, 8'h18);
      rd(`WDIT_ADDR_CNT, 8'h00);
      rd(`WDIT_ADDR_RSTC_RD, 8'h3F);
      rd(`WDIT_ADDR_RSTC_WR, 8'h00);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h27, 1'b0);
      wr(`WDIT_ADDR_CSR, 8'h3C, 8'h27);
      rd(`WDIT_ADDR_CSR, 8'h18);
      wr(`WDIT_ADDR_CNT, WDIT_KEY_CNT, 8'h80);
      rd(`WDIT_ADDR_CNT, 8'h00);
      // each clock select code: two counter steps in two prescaler periods
      for (int n = 0; n < 8; n++)
      begin
         wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, {5'b00100, n[2:0]});
         rd(`WDIT_ADDR_CSR, {5'b00111, n[2:0]});
         wr(`WDIT_ADDR_CSR, WDIT_KEY_CNT, 8'h00);
         repeat (2 * div_tab[n] - 1) @(posedge clock);
         rd(`WDIT_ADDR_CNT, 8'h02);
      end
      // interval mode overflow
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h20);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CNT, 8'hFE);
      wait_for(0, 1'b1, 10);
      rd(`WDIT_ADDR_CSR, 8'hB8);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'hA0);
      rd(`WDIT_ADDR_CSR, 8'hB8);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h20);
      #1 chk({7'h00, irq}, 8'h00);
      wait_for(0, 1'b1, 600);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h20);
      #1 chk({7'h00, irq}, 8'h01);
      rd(`WDIT_ADDR_CSR, 8'hB8);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h20);
      #1 chk({7'h00, irq}, 8'h00);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h00);
      rd(`WDIT_ADDR_CNT, 8'h00);
      // standby keeps the clock select only
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h67);
      @(posedge clock);
      standby <= 1'b1;
      @(posedge clock);
      standby <= 1'b0;
      rd(`WDIT_ADDR_CSR, 8'h1F);
      // watchdog overflow with the external output on, then off
      wr(`WDIT_ADDR_RSTC_WR, WDIT_KEY_CNT, 8'h40);
      rd(`WDIT_ADDR_RSTC_RD, 8'h7F);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h60);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CNT, 8'hFE);
      wait_for(1, 1'b1, 10);
      chk({7'h00, pin_level}, 8'h00);
      wait_for(1, 1'b0, 600);
      chk_n(int_len, 518);
      chk_n(ext_len, 132);
      rd(`WDIT_ADDR_CSR, 8'h18);
      rd(`WDIT_ADDR_RSTC_RD, 8'hFF);
      wr(`WDIT_ADDR_RSTC_WR, WDIT_KEY_CSR, 8'h01);
      rd(`WDIT_ADDR_RSTC_RD, 8'hFF);
      wr(`WDIT_ADDR_RSTC_WR, WDIT_KEY_CSR, 8'h00);
      rd(`WDIT_ADDR_RSTC_RD, 8'h7F);
      wr(`WDIT_ADDR_RSTC_WR, WDIT_KEY_CNT, 8'h00);
      rd(`WDIT_ADDR_RSTC_RD, 8'h3F);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CSR, 8'h60);
      wr(`WDIT_ADDR_CSR, WDIT_KEY_CNT, 8'hFE);
      wait_for(1, 1'b1, 10);
      wait_for(1, 1'b0, 600);
      chk_n(int_len, 518);
      chk_n(ext_len, 0);
      rd(`WDIT_ADDR_RSTC_RD, 8'hBF);
      // pin reset clears the reset control flags
      @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd(`WDIT_ADDR_RSTC_RD, 8'h3F);
      wrap_up();
   end
endmodule // watchdog_interval_timer_bench
`default_nettype wire
